//--- rtl/ppp_pkg.sv
package ppp_pkg;
   // register byte addresses on the internal register port
   localparam logic [7:0] PERSIST_ADDR   = 8'h8C;
   localparam logic [7:0] WAIT_CFG_ADDR  = 8'h8D;
   localparam logic [7:0] PULSE_CFG_ADDR = 8'h8E;
   // values after reset
   localparam logic [7:0] PERSIST_RST    = 8'h00;
   localparam logic [7:0] WAIT_CFG_RST   = 8'h40;
   localparam logic [7:0] PULSE_CFG_RST  = 8'h40;
   localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
   // field positions
   localparam int PROX_SEL_LSB  = 4;
   localparam int LIGHT_SEL_LSB = 0;
   localparam int LONG_WAIT_BIT = 1;
   localparam int WIDTH_SEL_LSB = 6;
   localparam int COUNT_SEL_LSB = 0;
   // timing, printed unit then clock cycles at 100 MHz
   localparam int CLK_PERIOD_PS   = 10000;
   localparam int WAIT_STEP_NS    = 2780000;
   localparam int WAIT_STEP_CYC   = WAIT_STEP_NS / (CLK_PERIOD_PS / 1000); // avoids int overflow
   localparam int STEP_CNT_W      = 19;
   localparam int LONG_WAIT_MULT  = 12;
   localparam int WIDTH_BASE_NS   = 4000;
   localparam int WIDTH_BASE_CYC  = (WIDTH_BASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int LED_EXTRA_NS    = 1360;
   localparam int LED_EXTRA_CYC   = (LED_EXTRA_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int LED_LEAD_CYC    = LED_EXTRA_CYC / 2;
   localparam int LED_TAIL_CYC    = LED_EXTRA_CYC - LED_LEAD_CYC;
   localparam int PULSE_GAP_NS    = 2000;
   localparam int PULSE_GAP_CYC   = (PULSE_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int PULSE_TMR_W     = 16;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ppp_reg_req_s;

   typedef struct packed {
      logic       done;
      logic [7:0] result;
      logic [7:0] low;
      logic [7:0] high;
   } ppp_prox_in_s;

   typedef struct packed {
      logic        done;
      logic [15:0] result;
      logic [15:0] low;
      logic [15:0] high;
   } ppp_light_in_s;

   // a result strictly outside its window
   function automatic logic ppp_out_of_range(input logic [15:0] v, input logic [15:0] lo,
                                             input logic [15:0] hi);
      return (v < lo) || (v > hi);
   endfunction

   // integration width in cycles for a 2-bit width selector
   function automatic logic [PULSE_TMR_W-1:0] ppp_width_cyc(input logic [1:0] sel);
      return PULSE_TMR_W'(WIDTH_BASE_CYC) << sel;
   endfunction
endpackage

//--- rtl/ppp_pulse_gen.sv
`timescale 1ns/100ps
module ppp_pulse_gen (
   input  wire logic       clk_sys,
   input  wire logic       resetn,
   input  wire logic       start,
   input  wire logic [5:0] count_sel,
   input  wire logic [1:0] width_sel,
   output logic            led_on,
   output logic            integ_on,
   output logic            busy,
   output logic            done
);
   import ppp_pkg::*;

   typedef enum logic [2:0] {PH_IDLE, PH_LEAD, PH_INTEG, PH_TAIL, PH_GAP} ppp_phase_e;
   typedef struct packed {
      ppp_phase_e             phase;
      logic [PULSE_TMR_W-1:0] tmr;
      logic [6:0]             left;
      logic [1:0]             wsel;
      logic                   led;
      logic                   integ;
      logic                   busy;
      logic                   done;
   } ppp_pulse_s;

   ppp_pulse_s s_reg;
   ppp_pulse_s s_next;

   assign led_on   = s_reg.led;
   assign integ_on = s_reg.integ;
   assign busy     = s_reg.busy;
   assign done     = s_reg.done;

   // led lead, integration, led tail, gap; led covers integration both sides
   always_comb begin
      s_next = s_reg;
      s_next.done = 1'b0;
      unique case (s_reg.phase)
         PH_IDLE: if (start) begin
            s_next.left  = {1'b0, count_sel} + 7'h01; // R13
            s_next.wsel  = width_sel;
            s_next.phase = PH_LEAD;
            s_next.tmr   = PULSE_TMR_W'(LED_LEAD_CYC - 1);
            s_next.led   = 1'b1; // R15
            s_next.busy  = 1'b1;
         end
         PH_LEAD: if (s_reg.tmr == '0) begin
            s_next.phase = PH_INTEG;
            s_next.tmr   = ppp_width_cyc(s_reg.wsel) - PULSE_TMR_W'(1); // R12
            s_next.integ = 1'b1;
         end else begin
            s_next.tmr = s_reg.tmr - PULSE_TMR_W'(1);
         end
         PH_INTEG: if (s_reg.tmr == '0) begin
            s_next.phase = PH_TAIL;
            s_next.tmr   = PULSE_TMR_W'(LED_TAIL_CYC - 1);
            s_next.integ = 1'b0;
         end else begin
            s_next.tmr = s_reg.tmr - PULSE_TMR_W'(1); // R14
         end
         PH_TAIL: if (s_reg.tmr == '0) begin
            s_next.led  = 1'b0;
            s_next.left = s_reg.left - 7'h01;
            if (s_reg.left == 7'h01) begin
               s_next.phase = PH_IDLE;
               s_next.busy  = 1'b0;
               s_next.done  = 1'b1;
            end else begin
               s_next.phase = PH_GAP;
               s_next.tmr   = PULSE_TMR_W'(PULSE_GAP_CYC - 1);
            end
         end else begin
            s_next.tmr = s_reg.tmr - PULSE_TMR_W'(1);
         end
         PH_GAP: if (s_reg.tmr == '0) begin
            s_next.phase = PH_LEAD;
            s_next.tmr   = PULSE_TMR_W'(LED_LEAD_CYC - 1);
            s_next.led   = 1'b1;
         end else begin
            s_next.tmr = s_reg.tmr - PULSE_TMR_W'(1);
         end
         default: s_next.phase = PH_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // helper counters: integration run length and pulses in a burst
   logic [PULSE_TMR_W-1:0] integ_len;
   logic [6:0]             pulses_seen;
   logic [6:0]             pulses_want;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         integ_len   <= '0;
         pulses_seen <= '0;
         pulses_want <= '0;
      end else begin
         integ_len <= s_reg.integ ? integ_len + PULSE_TMR_W'(1) : '0;
         if (start && !s_reg.busy) begin
            pulses_seen <= '0;
            pulses_want <= {1'b0, count_sel} + 7'h01;
         end else if (s_next.integ && !s_reg.integ) begin
            pulses_seen <= pulses_seen + 7'h01;
         end
      end
   end

   property p_width;
      @(posedge clk_sys) disable iff (!resetn)
      $fell(s_reg.integ) |-> integ_len == ppp_width_cyc(s_reg.wsel);
   endproperty
   a_width: assert property (p_width) else $error("integration width wrong"); // R14

   property p_count;
      @(posedge clk_sys) disable iff (!resetn)
      s_reg.done |-> pulses_seen == pulses_want;
   endproperty
   a_count: assert property (p_count) else $error("pulse count wrong"); // R13

   property p_led_cover;
      @(posedge clk_sys) disable iff (!resetn)
      $rose(s_reg.integ) |-> $past(s_reg.led) ##0 s_reg.led [*1] ##1 1'b1;
   endproperty
   a_led_cover: assert property (p_led_cover) else $error("led not on before window"); // R15

   property p_led_tail;
      @(posedge clk_sys) disable iff (!resetn)
      $fell(s_reg.integ) |-> s_reg.led [*8];
   endproperty
   a_led_tail: assert property (p_led_tail) else $error("led dropped right after window"); // R15
endmodule

//--- rtl/ppp_ctrl.sv
// Function
// R1: count out-of-range cycles, compare with persistence
// R2: in-window result clears that channel count
// R3: separate proximity and light counters
// R4: proximity selector high nibble, zero fires always
// R5: proximity selector N needs N misses
// R6: light selector low nibble, zero always
// R7: light 2,3 direct; above: 5 times (v-3)
// R8: wait configuration resets to 40 hex
// R9: long-wait bit multiplies wait by twelve
// R10: reserved wait bits default set, host keeps
// R11: host keeps bit five set, saves power
// R12: width field selects 4/8/16/32 us
// R13: count field plus one pulses per cycle
// R14: led sinks for selected width per pulse
// R15: led on slightly longer than integration
// R16: pulse register resets to 40 hex
// R17: proximity interrupt needs its enable bit
// R18: light miss outside 16-bit window, enable
// R19: proximity miss outside 8-bit window
// R20: wait counted in 2.78 ms steps
// R21: counters saturate and restart after firing
`timescale 1ns/100ps
module ppp_ctrl #(
   parameter int WAIT_STEP_CYCLES = ppp_pkg::WAIT_STEP_CYC
) (
   input  wire logic                   clk_sys,
   input  wire logic                   resetn,
   input  wire ppp_pkg::ppp_reg_req_s  reg_req,
   output logic [7:0]                  reg_rdata,
   output logic                        reg_rvalid,
   input  wire ppp_pkg::ppp_prox_in_s  prox_in,
   input  wire ppp_pkg::ppp_light_in_s light_in,
   input  wire logic                   prox_irq_enable,
   input  wire logic                   light_irq_enable,
   input  wire logic [7:0]             wait_period_setting,
   input  wire logic                   wait_start,
   input  wire logic                   pulse_start,
   output logic                        prox_irq_event,
   output logic                        light_irq_event,
   output logic                        wait_busy,
   output logic                        wait_done,
   output logic                        led_sink_pin_on,
   output logic                        integ_window,
   output logic                        pulse_busy,
   output logic                        pulse_done
);
   import ppp_pkg::*;

   typedef struct packed {
      logic [7:0]            persist;
      logic [7:0]            wait_cfg;
      logic [7:0]            pulse_cfg;
      logic [3:0]            prox_cnt;
      logic [5:0]            light_cnt;
      logic                  prox_irq;
      logic                  light_irq;
      logic [7:0]            rdata;
      logic                  rvalid;
      logic                  wbusy;
      logic [STEP_CNT_W-1:0] step_cnt;
      logic [11:0]           steps_left;
      logic                  wdone;
   } ppp_ctrl_s;

   ppp_ctrl_s s_reg;
   ppp_ctrl_s s_next;

   // light persistence table: direct up to 3, then steps of five
   function automatic logic [5:0] ppp_light_need(input logic [3:0] v);
      if (v <= 4'h3) begin
         return {2'b00, v};
      end
      return 6'(({2'b00, v} - 6'h03) * 6'h05);
   endfunction

   // wait steps for a two's complement period and the long flag
   function automatic logic [11:0] ppp_wait_steps(input logic [7:0] wp, input logic lng);
      logic [11:0] base;
      base = 12'h100 - {4'h0, wp};
      return 12'(base * (lng ? 12'(LONG_WAIT_MULT) : 12'h001));
   endfunction

   logic [3:0]  prox_sel;
   logic [3:0]  light_sel;
   logic [5:0]  light_need;
   logic        prox_miss;
   logic        light_miss;
   logic [3:0]  prox_inc;
   logic [5:0]  light_inc;
   logic        long_wait_flag;
   logic [1:0]  prox_pulse_width_sel;
   logic [5:0]  prox_pulse_number;
   logic [STEP_CNT_W-1:0] step_last;

   // decoded register fields
   assign prox_sel             = s_reg.persist[PROX_SEL_LSB +: 4]; // R4
   assign light_sel            = s_reg.persist[LIGHT_SEL_LSB +: 4]; // R6
   assign light_need           = ppp_light_need(light_sel); // R7
   assign long_wait_flag       = s_reg.wait_cfg[LONG_WAIT_BIT];
   assign prox_pulse_width_sel = s_reg.pulse_cfg[WIDTH_SEL_LSB +: 2];
   assign prox_pulse_number    = s_reg.pulse_cfg[COUNT_SEL_LSB +: 6];
   assign step_last            = STEP_CNT_W'(WAIT_STEP_CYCLES - 1);

   // window compares, proximity widened to the shared 16-bit compare
   assign prox_miss  = ppp_out_of_range({8'h00, prox_in.result}, {8'h00, prox_in.low},
                                        {8'h00, prox_in.high}); // R19
   assign light_miss = ppp_out_of_range(light_in.result, light_in.low, light_in.high); // R18

   // saturating increments, never wrap even if the selector shrinks mid-run
   assign prox_inc  = (s_reg.prox_cnt == 4'hF) ? 4'hF : s_reg.prox_cnt + 4'h1; // R21
   assign light_inc = (s_reg.light_cnt == 6'h3F) ? 6'h3F : s_reg.light_cnt + 6'h01; // R21

   assign reg_rdata       = s_reg.rdata;
   assign reg_rvalid      = s_reg.rvalid;
   assign prox_irq_event  = s_reg.prox_irq;
   assign light_irq_event = s_reg.light_irq;
   assign wait_busy       = s_reg.wbusy;
   assign wait_done       = s_reg.wdone;

   // register port, persistence filters and wait timer
   always_comb begin
      s_next = s_reg;
      s_next.rvalid    = 1'b0;
      s_next.prox_irq  = 1'b0;
      s_next.light_irq = 1'b0;
      s_next.wdone     = 1'b0;

      // writes store whole bytes; reserved bits hold what the host writes
      if (reg_req.wr) begin
         unique case (reg_req.addr)
            PERSIST_ADDR:   s_next.persist   = reg_req.wdata;
            WAIT_CFG_ADDR:  s_next.wait_cfg  = reg_req.wdata; // R10
            PULSE_CFG_ADDR: s_next.pulse_cfg = reg_req.wdata;
            default: ;
         endcase
      end
      // reads answer one cycle later; unmapped addresses read zero
      if (reg_req.rd) begin
         s_next.rvalid = 1'b1;
         unique case (reg_req.addr)
            PERSIST_ADDR:   s_next.rdata = s_reg.persist;
            WAIT_CFG_ADDR:  s_next.rdata = s_reg.wait_cfg;
            PULSE_CFG_ADDR: s_next.rdata = s_reg.pulse_cfg;
            default:        s_next.rdata = RDATA_UNMAPPED;
         endcase
      end

      // proximity filter touches only its own counter
      if (prox_in.done) begin // R3
         if (prox_sel == 4'h0) begin
            s_next.prox_cnt = 4'h0;
            s_next.prox_irq = prox_irq_enable; // R4 R17
         end else if (prox_miss) begin
            if (prox_inc >= prox_sel) begin // R1
               s_next.prox_cnt = 4'h0; // R21
               s_next.prox_irq = prox_irq_enable; // R5 R17
            end else begin
               s_next.prox_cnt = prox_inc;
            end
         end else begin
            s_next.prox_cnt = 4'h0; // R2
         end
      end

      // light filter, same scheme with the stretched table
      if (light_in.done) begin // R3
         if (light_sel == 4'h0) begin
            s_next.light_cnt = 6'h00;
            s_next.light_irq = light_irq_enable; // R6
         end else if (light_miss) begin
            if (light_inc >= light_need) begin // R1
               s_next.light_cnt = 6'h00; // R21
               s_next.light_irq = light_irq_enable; // R18
            end else begin
               s_next.light_cnt = light_inc;
            end
         end else begin
            s_next.light_cnt = 6'h00; // R2
         end
      end

      // wait timer: a restart while busy reloads, so a late start is never lost
      if (wait_start) begin
         s_next.wbusy      = 1'b1;
         s_next.step_cnt   = '0;
         s_next.steps_left = ppp_wait_steps(wait_period_setting, long_wait_flag); // R9
      end else if (s_reg.wbusy) begin
         if (s_reg.step_cnt == step_last) begin // R20
            s_next.step_cnt = '0;
            if (s_reg.steps_left == 12'h001) begin
               s_next.wbusy = 1'b0;
               s_next.wdone = 1'b1;
            end else begin
               s_next.steps_left = s_reg.steps_left - 12'h001;
            end
         end else begin
            s_next.step_cnt = s_reg.step_cnt + STEP_CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         s_reg           <= '0;
         s_reg.persist   <= PERSIST_RST;
         s_reg.wait_cfg  <= WAIT_CFG_RST; // R8
         s_reg.pulse_cfg <= PULSE_CFG_RST; // R16
      end else begin
         s_reg <= s_next;
      end
   end

   // led pulse train; the start is ignored while a burst runs
   ppp_pulse_gen u_pulse (
      .clk_sys   (clk_sys),
      .resetn    (resetn),
      .start     (pulse_start),
      .count_sel (prox_pulse_number),
      .width_sel (prox_pulse_width_sel),
      .led_on    (led_sink_pin_on),
      .integ_on  (integ_window),
      .busy      (pulse_busy),
      .done      (pulse_done)
   );

   property p_prox_every;
      @(posedge clk_sys) disable iff (!resetn)
      prox_in.done && prox_sel == 4'h0 |=> s_reg.prox_irq == $past(prox_irq_enable);
   endproperty
   a_prox_every: assert property (p_prox_every) else $error("zero selector missed"); // R4

   property p_prox_fire;
      @(posedge clk_sys) disable iff (!resetn)
      prox_in.done && prox_sel != 4'h0 && prox_miss && prox_irq_enable
         && (s_reg.prox_cnt + 4'h1) == prox_sel |=> s_reg.prox_irq && s_reg.prox_cnt == 4'h0;
   endproperty
   a_prox_fire: assert property (p_prox_fire) else $error("proximity did not fire"); // R5

   property p_prox_early;
      @(posedge clk_sys) disable iff (!resetn)
      prox_in.done && prox_sel != 4'h0 && (s_reg.prox_cnt + 4'h1) < prox_sel
         |=> !s_reg.prox_irq;
   endproperty
   a_prox_early: assert property (p_prox_early) else $error("proximity fired early"); // R1

   property p_prox_clear;
      @(posedge clk_sys) disable iff (!resetn)
      prox_in.done && !prox_miss |=> s_reg.prox_cnt == 4'h0;
   endproperty
   a_prox_clear: assert property (p_prox_clear) else $error("in-window did not clear"); // R2

   property p_light_fire;
      @(posedge clk_sys) disable iff (!resetn)
      light_in.done && light_sel != 4'h0 && light_miss && light_irq_enable
         && s_reg.light_cnt == light_need - 6'h01 |=> s_reg.light_irq;
   endproperty
   a_light_fire: assert property (p_light_fire) else $error("light did not fire"); // R7

   property p_light_early;
      @(posedge clk_sys) disable iff (!resetn)
      light_in.done && light_sel != 4'h0 && (s_reg.light_cnt + 6'h01) < light_need
         |=> !s_reg.light_irq;
   endproperty
   a_light_early: assert property (p_light_early) else $error("light fired early"); // R1

   property p_light_clear;
      @(posedge clk_sys) disable iff (!resetn)
      light_in.done && !light_miss |=> s_reg.light_cnt == 6'h00;
   endproperty
   a_light_clear: assert property (p_light_clear) else $error("light in-window kept count"); // R2

   property p_light_table;
      @(posedge clk_sys) disable iff (!resetn)
      light_sel == 4'hF |-> light_need == 6'h3C;
   endproperty
   a_light_table: assert property (p_light_table) else $error("light table top wrong"); // R7

   property p_indep;
      @(posedge clk_sys) disable iff (!resetn)
      light_in.done && !prox_in.done |=> $stable(s_reg.prox_cnt);
   endproperty
   a_indep: assert property (p_indep) else $error("light changed proximity count"); // R3

   property p_enable;
      @(posedge clk_sys) disable iff (!resetn)
      !prox_irq_enable && !light_irq_enable |=> !s_reg.prox_irq && !s_reg.light_irq;
   endproperty
   a_enable: assert property (p_enable) else $error("interrupt while disabled"); // R17

   property p_sat;
      @(posedge clk_sys) disable iff (!resetn)
      s_reg.prox_cnt != 4'hF && s_reg.light_cnt < 6'h3C;
   endproperty
   a_sat: assert property (p_sat) else $error("persistence count overran"); // R21

   property p_wait_load;
      @(posedge clk_sys) disable iff (!resetn)
      wait_start && long_wait_flag && wait_period_setting == 8'hFF
         |=> s_reg.steps_left == 12'h00C && s_reg.wbusy;
   endproperty
   a_wait_load: assert property (p_wait_load) else $error("long wait not twelvefold"); // R9

   property p_wait_done;
      @(posedge clk_sys) disable iff (!resetn)
      s_reg.wdone |-> $past(s_reg.wbusy) && !s_reg.wbusy;
   endproperty
   a_wait_done: assert property (p_wait_done) else $error("wait done without run"); // R20
endmodule

//--- dv/ppp_host_model.sv
`timescale 1ns/100ps
// host side of the register port; strobes move only on falling edges
module ppp_host_model (
   input  wire logic             clk_sys,
   output ppp_pkg::ppp_reg_req_s reg_req,
   input  wire logic [7:0]       reg_rdata,
   input  wire logic             reg_rvalid
);
   import ppp_pkg::*;

   initial reg_req = '0;

   // released lines flip, so a stale copy is never mistaken for data
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge clk_sys);
      reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask

   // answer is awaited under a bound, taken on a rising edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      d = 'x; // a missing answer must not look like a zero register
      @(negedge clk_sys);
      reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: reg_req.wdata};
      @(negedge clk_sys);
      reg_req.rd <= 1'b0;
      reg_req.addr <= ~a;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys);
         if (reg_rvalid === 1'b1) begin
            d = reg_rdata;
            break;
         end
      end
   endtask

   // reserved bits 6 and 5 kept set, bit 1 taken from lw, the rest written as zero
   task automatic set_long(input logic lw);
      wr(WAIT_CFG_ADDR, {6'h18, lw, 1'b0});
   endtask
endmodule

//--- dv/ppp_ctrl_test.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_total++; \
   $display("ERROR %0t: mismatch got %0h exp %0h", $time, got, exp); end end
module ppp_ctrl_test;
   import ppp_pkg::*;
   localparam int STEP  = 4;
   localparam int LIMIT = 30000;
   typedef struct packed {logic [7:0] interrupt_persistence; logic lt; logic inw; logic [7:0] need;} ppp_row_s;
   // persistence selector, channel, in-window flag, results to the event
   ppp_row_s rows [11] = '{'{8'h00, 0, 1, 1}, '{8'h10, 0, 0, 1}, '{8'h20, 0, 0, 2},
      '{8'hF0, 0, 0, 15}, '{8'h00, 1, 1, 1}, '{8'h01, 1, 0, 1}, '{8'h02, 1, 0, 2},
      '{8'h03, 1, 0, 3}, '{8'h04, 1, 0, 5}, '{8'h05, 1, 0, 10}, '{8'h0F, 1, 0, 60}};
   logic          clk_sys = 1'b0;
   logic          resetn = 1'b0;
   ppp_reg_req_s  reg_req;
   ppp_prox_in_s  prox_in;
   ppp_light_in_s light_in;
   logic [7:0]    reg_rdata, rd_val, wait_set;
   logic          reg_rvalid, prox_irq_event, light_irq_event, wait_busy, wait_done, flip;
   logic          led_on, integ_window, pulse_busy, pulse_done;
   logic          prox_en, light_en, wait_start, pulse_start;
   int            err_total, cmp_count, cyc, n_pirq, n_lirq, t_ws, t_wd, n_rise, n_pdone;
   int            led_run, led_len, int_run, int_len, p0, l0;

   always #5 clk_sys = ~clk_sys;

   ppp_ctrl #(.WAIT_STEP_CYCLES(STEP)) i_dut (.clk_sys(clk_sys), .resetn(resetn),
      .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .prox_in(prox_in),
      .light_in(light_in), .prox_irq_enable(prox_en), .light_irq_enable(light_en),
      .wait_period_setting(wait_set), .wait_start(wait_start), .pulse_start(pulse_start),
      .prox_irq_event(prox_irq_event), .light_irq_event(light_irq_event),
      .wait_busy(wait_busy), .wait_done(wait_done), .led_sink_pin_on(led_on),
      .integ_window(integ_window), .pulse_busy(pulse_busy), .pulse_done(pulse_done));
   ppp_host_model i_host (.clk_sys(clk_sys), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid));

   task automatic results();
      $display("comparisons %0d errors %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // event counts, timestamps and pulse lengths; also cuts a hang short
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (prox_irq_event) n_pirq <= n_pirq + 1;
      if (light_irq_event) n_lirq <= n_lirq + 1;
      if (wait_start) t_ws <= cyc;
      if (wait_done) t_wd <= cyc;
      if (pulse_done) n_pdone <= n_pdone + 1;
      if (led_on && led_run == 0) n_rise <= n_rise + 1;
      led_run <= led_on ? led_run + 1 : 0;
      int_run <= integ_window ? int_run + 1 : 0;
      if (!led_on && led_run != 0) led_len <= led_run;
      if (!integ_window && int_run != 0) int_len <= int_run;
      if (cyc == LIMIT) begin
         err_total++;
         results();
      end
   end

   // one result per channel; misses alternate below low and above high
   task automatic send(input logic pv, input logic lv, input logic pm, input logic lm);
      @(negedge clk_sys);
      flip = ~flip;
      prox_in <= '{pv, pm ? (flip ? 8'h05 : 8'hFA) : 8'h80, 8'h10, 8'hF0};
      light_in <= '{lv, lm ? (flip ? 16'hFFFA : 16'h0005) : 16'h8000, 16'h0100, 16'hF000};
      @(negedge clk_sys);
      prox_in.done <= 1'b0;
      light_in.done <= 1'b0;
      @(negedge clk_sys);
   endtask

   // burst with a second start mid-way, which must be ignored
   task automatic burst(input int pulses, input int width_cyc);
      int r0;
      int d0;
      r0 = n_rise;
      d0 = n_pdone;
      @(negedge clk_sys) pulse_start <= 1'b1;
      @(negedge clk_sys) pulse_start <= 1'b0;
      `CHK(pulse_busy, 1'b1)
      repeat (50) @(negedge clk_sys);
      pulse_start <= 1'b1;
      @(negedge clk_sys) pulse_start <= 1'b0;
      for (int k = 0; k < 20000 && n_pdone == d0; k++) @(negedge clk_sys);
      `CHK(n_rise - r0, pulses)
      `CHK(led_len, width_cyc + 136)
      `CHK(int_len, width_cyc)
      `CHK(n_pdone - d0, 1)
      `CHK(pulse_busy, 1'b0)
   endtask

   initial begin
      prox_in = '0;
      light_in = '0;
      flip = 1'b0;
      prox_en = 1'b1;
      light_en = 1'b1;
      wait_set = 8'hFE;
      wait_start = 1'b0;
      pulse_start = 1'b0;
      repeat (16) @(posedge clk_sys);
      @(negedge clk_sys) resetn = 1'b1;
      // values after reset, and an unmapped address
      i_host.rd(PERSIST_ADDR, rd_val);
      `CHK(rd_val, PERSIST_RST)
      i_host.rd(WAIT_CFG_ADDR, rd_val);
      `CHK(rd_val, 8'h40)
      i_host.rd(PULSE_CFG_ADDR, rd_val);
      `CHK(rd_val, 8'h40)
      i_host.rd(8'h90, rd_val);
      `CHK(rd_val, RDATA_UNMAPPED)
      // default pulse setting first: 8 us, single pulse
      burst(1, 800);
      // table of persistence settings, one channel at a time
      foreach (rows[i]) begin
         i_host.wr(PERSIST_ADDR, rows[i].interrupt_persistence);
         p0 = n_pirq;
         l0 = n_lirq;
         for (int k = 1; k <= rows[i].need; k++) begin
            send(!rows[i].lt, rows[i].lt, !rows[i].inw, !rows[i].inw);
            `CHK(n_pirq - p0, (!rows[i].lt && k == rows[i].need) ? 1 : 0)
            `CHK(n_lirq - l0, (rows[i].lt && k == rows[i].need) ? 1 : 0)
         end
      end
      // enables low: no event even with selector zero
      prox_en = 1'b0;
      light_en = 1'b0;
      i_host.wr(PERSIST_ADDR, 8'h00);
      p0 = n_pirq;
      l0 = n_lirq;
      send(1, 1, 1, 1);
      `CHK(n_pirq - p0, 0)
      `CHK(n_lirq - l0, 0)
      prox_en = 1'b1;
      light_en = 1'b1;
      // in-window result breaks the run; count restarts after an event
      i_host.wr(PERSIST_ADDR, 8'h33);
      for (int j = 0; j < 2; j++) begin
         p0 = n_pirq;
         l0 = n_lirq;
         for (int k = 0; k < 9; k++) begin
            send(1, 1, k != 2, j == 0 && k != 2);
            `CHK(n_pirq - p0, (k >= 5) + (k >= 8))
            `CHK(n_lirq - l0, j == 0 ? (k >= 5) + (k >= 8) : 0)
         end
      end
      // wait of two plain steps, then one step twelvefold
      for (int w = 0; w < 2; w++) begin
         i_host.set_long(w[0]);
         wait_set = w ? 8'hFF : 8'hFE;
         @(negedge clk_sys) wait_start <= 1'b1;
         @(negedge clk_sys) wait_start <= 1'b0;
         `CHK(wait_busy, 1'b1)
         for (int k = 0; k < 200 && wait_done !== 1'b1; k++) @(negedge clk_sys);
         @(negedge clk_sys);
         `CHK(wait_busy, 1'b0)
         `CHK(t_wd - t_ws, (256 - wait_set) * STEP * (w ? LONG_WAIT_MULT : 1) + 1)
      end
      i_host.rd(WAIT_CFG_ADDR, rd_val);
      `CHK(rd_val, 8'h62)
      // every width code, then a three-pulse burst
      for (int w = 0; w < 4; w++) begin
         i_host.wr(PULSE_CFG_ADDR, {w[1:0], 6'h00});
         burst(1, 400 << w);
      end
      i_host.wr(PULSE_CFG_ADDR, 8'h02);
      i_host.rd(PULSE_CFG_ADDR, rd_val);
      `CHK(rd_val, 8'h02)
      burst(3, 400);
      results();
   end
endmodule
